// ### rtl/fault_status_pkg.sv
/*
 * Constants, types and register map for the sticky voltage fault status bank.
 * Assumes a serial management front end that turns bus traffic into
 * single-cycle register read and write strobes.
 */
package fault_status_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned STAT_W = 24;

	// Register offsets
	localparam logic [ADDR_W-1:0] VOLT_LOW_OFS  = 8'h41;
	localparam logic [ADDR_W-1:0] VOLT_HIGH_OFS = 8'h42;
	localparam logic [ADDR_W-1:0] MISC_OFS      = 8'h43;
	localparam logic [DATA_W-1:0] REG_RESET     = 8'h00;
	localparam logic [DATA_W-1:0] UNMAPPED_DATA = 8'h00;

	// Flat status vector: [7:0] low bank, [15:8] high bank, [23:16] misc
	localparam int unsigned LOW_LSB  = 0;
	localparam int unsigned HIGH_LSB = 8;
	localparam int unsigned MISC_LSB = 16;
	localparam int unsigned CH15_BIT = 14;
	localparam int unsigned CH16_BIT = 15;

	localparam logic [STAT_W-1:0] STAT_RESET = 24'h00_0000;
	// Misc bits 1:0 are reserved
	localparam logic [STAT_W-1:0] IMPL_BITS  = 24'hFC_FFFF;
	// Always masked while asleep
	localparam logic [STAT_W-1:0] FIXED_MASK = 24'h3C_47FF;
	// Masked only as the sleep mask settings say
	localparam logic [STAT_W-1:0] OPT_MASK   = 24'hC0_3800;

	typedef enum logic [2:0] {
		SLEEP_S0  = 3'b001,
		SLEEP_S3  = 3'b010,
		SLEEP_S45 = 3'b100
	} sleep_state_t;

	typedef struct packed {
		logic [15:0] voltRange;    // Channel n+1 outside its limits
		logic [1:0]  termFuse;     // Termination fuse inputs 2,1
		logic [1:0]  coreMismatch; // Core supply vs voltage id, cpu 2,1
		logic [1:0]  diodeFault;   // Remote diode open/short, 2,1
	} fault_in_t;

	typedef struct packed {
		logic                rdEn;
		logic                wrEn;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   wrData;
	} reg_req_t;

endpackage : fault_status_pkg

// ### rtl/voltage_fault_status_bank.sv
/*
 * Three sticky 8-bit fault status registers with sleep-state masking.
 * Assumes fault inputs are levels synchronous to clk and that register
 * strobes last one cycle each.
 */
// Operation
// - Channels 1-8 set low bank; masked asleep
// - Channels 9-16 set high bank; 9-11 masked asleep
// - Channels 12-14 masked asleep per mask settings
// - Channel 15 always masked asleep
// - Channel 16 never masked by sleep
// - Fuse input 1 sets misc bit 2
// - Fuse input 2 sets misc bit 3
// - Cpu1 core mismatch sets misc bit 4
// - Cpu2 core mismatch sets misc bit 5
// - Diode 1 fault sets bit 6, optional mask
// - Diode 2 fault sets bit 7, optional mask
// - Set bits stay until software clears
// - Clear fails while fault unmasked and present
// - ASF: read clears too; else write-one-clear
// - Any bit sets summary flag; alert if enabled
module voltage_fault_status_bank (
	input  wire logic                                clk,             // 200 MHz clock
	input  wire logic                                rst_b,           // Async reset, low
	input  wire fault_status_pkg::reg_req_t          regReq,          // Register strobe
	output logic [fault_status_pkg::DATA_W-1:0]      regRdData_q,     // Read data
	input  wire fault_status_pkg::fault_in_t         faultIn,         // Fault levels
	input  wire fault_status_pkg::sleep_state_t      sleepState,      // Sleep state
	input  wire logic [fault_status_pkg::STAT_W-1:0] s3OptMask,       // Opt. mask in S3
	input  wire logic [fault_status_pkg::STAT_W-1:0] s45OptMask,      // Opt. mask in S4/5
	input  wire logic                                asfMode,         // Read-to-clear mode
	input  wire logic                                alertEnable,     // Alert enable
	output logic                                     summaryErrFlag_q, // Summary flag
	output logic                                     alert_q          // Alert output
);

	localparam int unsigned SW = fault_status_pkg::STAT_W;

	logic [SW-1:0] status_q;
	logic [SW-1:0] status_d;
	logic [SW-1:0] condVec;
	logic [SW-1:0] maskVec;
	logic [SW-1:0] setVec;
	logic [SW-1:0] clrVec;
	logic [SW-1:0] wrClr;
	logic [SW-1:0] rdClr;
	logic [fault_status_pkg::DATA_W-1:0] rdMux;
	logic inS3;
	logic inS45;
	logic selLow;
	logic selHigh;
	logic selMisc;

	// Condition map
	assign condVec[fault_status_pkg::LOW_LSB +: 8]  = faultIn.voltRange[7:0];
	assign condVec[fault_status_pkg::HIGH_LSB +: 8] = faultIn.voltRange[15:8];
	assign condVec[fault_status_pkg::MISC_LSB +: 8] = {faultIn.diodeFault[1],
		faultIn.diodeFault[0],
		faultIn.coreMismatch[1],
		faultIn.coreMismatch[0],
		faultIn.termFuse[1],
		faultIn.termFuse[0],
		2'b00};

	// Unknown sleep codes count as awake so faults are never lost
	assign inS3  = (sleepState == fault_status_pkg::SLEEP_S3);
	assign inS45 = (sleepState == fault_status_pkg::SLEEP_S45);

	assign maskVec = ({SW{inS3 | inS45}} & fault_status_pkg::FIXED_MASK)
		| ({SW{inS3}} & s3OptMask & fault_status_pkg::OPT_MASK)
		| ({SW{inS45}} & s45OptMask & fault_status_pkg::OPT_MASK);

	assign setVec = condVec & ~maskVec & fault_status_pkg::IMPL_BITS;

	// Address decode
	assign selLow  = (regReq.addr == fault_status_pkg::VOLT_LOW_OFS);
	assign selHigh = (regReq.addr == fault_status_pkg::VOLT_HIGH_OFS);
	assign selMisc = (regReq.addr == fault_status_pkg::MISC_OFS);

	assign wrClr = {SW{regReq.wrEn}} & {{8{selMisc}}, {8{selHigh}}, {8{selLow}}}
		& {3{regReq.wrData}};
	assign rdClr = {SW{regReq.rdEn & asfMode}}
		& {{8{selMisc}}, {8{selHigh}}, {8{selLow}}};
	assign clrVec = wrClr | rdClr;

	// Set beats clear, so an unmasked live fault cannot be cleared
	assign status_d = (setVec | (status_q & ~clrVec)) & fault_status_pkg::IMPL_BITS;

	assign rdMux = selLow  ? status_q[fault_status_pkg::LOW_LSB +: 8]
		: selHigh ? status_q[fault_status_pkg::HIGH_LSB +: 8]
		: selMisc ? status_q[fault_status_pkg::MISC_LSB +: 8]
		: fault_status_pkg::UNMAPPED_DATA;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			status_q <= fault_status_pkg::STAT_RESET;
		end else begin
			status_q <= status_d;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			regRdData_q <= fault_status_pkg::REG_RESET;
		end else if (regReq.rdEn) begin
			regRdData_q <= rdMux;
		end
	end

	// Flag tracks the registered status exactly
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			summaryErrFlag_q <= 1'b0;
			alert_q          <= 1'b0;
		end else begin
			summaryErrFlag_q <= |status_d;
			alert_q          <= alertEnable & (|status_d);
		end
	end

	// Checks
	lowSleepQuiet_a: assert property (@(posedge clk) disable iff (!rst_b)
		((inS3 || inS45) && status_q[7:0] == 8'h00) |=> status_q[7:0] == 8'h00)
		else $error("low bank set while asleep");

	highAwakeSet_a: assert property (@(posedge clk) disable iff (!rst_b)
		(sleepState == fault_status_pkg::SLEEP_S0 && faultIn.voltRange[8])
		|=> status_q[8])
		else $error("channel 9 fault not latched");

	optMask_a: assert property (@(posedge clk) disable iff (!rst_b)
		(inS3 && !s3OptMask[11] && faultIn.voltRange[11]) |=> status_q[11])
		else $error("unmasked channel 12 fault not latched");

	ch15Mask_a: assert property (@(posedge clk) disable iff (!rst_b)
		((inS3 || inS45) && !status_q[fault_status_pkg::CH15_BIT])
		|=> !status_q[fault_status_pkg::CH15_BIT])
		else $error("channel 15 set while asleep");

	ch16Never_a: assert property (@(posedge clk) disable iff (!rst_b)
		faultIn.voltRange[15] |=> status_q[fault_status_pkg::CH16_BIT])
		else $error("channel 16 fault lost");

	fuseSet_a: assert property (@(posedge clk) disable iff (!rst_b)
		(!inS3 && !inS45 && faultIn.termFuse[0]) |=> status_q[18])
		else $error("fuse 1 fault not latched");

	stickyBit_a: assert property (@(posedge clk) disable iff (!rst_b)
		(status_q[0] && !regReq.wrEn && !regReq.rdEn) |=> status_q[0])
		else $error("status bit dropped without clear");

	clearFail_a: assert property (@(posedge clk) disable iff (!rst_b)
		(faultIn.voltRange[15] && regReq.wrEn && selHigh)
		|=> status_q[fault_status_pkg::CH16_BIT])
		else $error("live unmasked fault was cleared");

	asfRead_a: assert property (@(posedge clk) disable iff (!rst_b)
		(regReq.rdEn && asfMode && selLow && faultIn.voltRange[7:0] == 8'h00)
		|=> status_q[7:0] == 8'h00)
		else $error("read did not clear in ASF mode");

	plainRead_a: assert property (@(posedge clk) disable iff (!rst_b)
		(regReq.rdEn && !regReq.wrEn && !asfMode && selLow && status_q[0])
		|=> status_q[0])
		else $error("read cleared outside ASF mode");

	summaryFlag_a: assert property (@(posedge clk) disable iff (!rst_b)
		summaryErrFlag_q == (|status_q))
		else $error("summary flag disagrees with status");

	alertOut_a: assert property (@(posedge clk) disable iff (!rst_b)
		##1 alert_q == ($past(alertEnable) && summaryErrFlag_q))
		else $error("alert does not follow enabled summary");

	rsvdZero_a: assert property (@(posedge clk) disable iff (!rst_b)
		status_q[17:16] == 2'b00)
		else $error("reserved misc bits set");

	lowAwakeSet_a: assert property (@(posedge clk) disable iff (!rst_b)
		(!inS3 && !inS45 && faultIn.voltRange[0]) |=> status_q[0])
		else $error("channel 1 fault not latched");

	highSleepQuiet_a: assert property (@(posedge clk) disable iff (!rst_b)
		((inS3 || inS45) && !status_q[8]) |=> !status_q[8])
		else $error("channel 9 set while asleep");

	optMaskHold_a: assert property (@(posedge clk) disable iff (!rst_b)
		(inS45 && s45OptMask[12] && !status_q[12]) |=> !status_q[12])
		else $error("masked channel 13 set while asleep");

	miscSleepQuiet_a: assert property (@(posedge clk) disable iff (!rst_b)
		((inS3 || inS45) && status_q[21:18] == 4'h0) |=> status_q[21:18] == 4'h0)
		else $error("fuse or core bit set while asleep");

	fuse2Set_a: assert property (@(posedge clk) disable iff (!rst_b)
		(!inS3 && !inS45 && faultIn.termFuse[1]) |=> status_q[19])
		else $error("fuse 2 fault not latched");

	cpu1Set_a: assert property (@(posedge clk) disable iff (!rst_b)
		(!inS3 && !inS45 && faultIn.coreMismatch[0]) |=> status_q[20])
		else $error("cpu 1 core mismatch not latched");

	cpu2Set_a: assert property (@(posedge clk) disable iff (!rst_b)
		(!inS3 && !inS45 && faultIn.coreMismatch[1]) |=> status_q[21])
		else $error("cpu 2 core mismatch not latched");

	diode1Set_a: assert property (@(posedge clk) disable iff (!rst_b)
		(inS3 && !s3OptMask[22] && faultIn.diodeFault[0]) |=> status_q[22])
		else $error("unmasked diode 1 fault not latched");

	diode2Set_a: assert property (@(posedge clk) disable iff (!rst_b)
		(!inS3 && !inS45 && faultIn.diodeFault[1]) |=> status_q[23])
		else $error("diode 2 fault not latched");

	diodeMask_a: assert property (@(posedge clk) disable iff (!rst_b)
		(inS3 && s3OptMask[23] && !status_q[23]) |=> !status_q[23])
		else $error("masked diode 2 set while asleep");

	maskedClear_a: assert property (@(posedge clk) disable iff (!rst_b)
		((inS3 || inS45) && regReq.wrEn && selLow && regReq.wrData[0]) |=> !status_q[0])
		else $error("masked fault bit did not clear");

	rsvdRead_a: assert property (@(posedge clk) disable iff (!rst_b)
		(regReq.rdEn && selMisc) |=> regRdData_q[1:0] == 2'b00)
		else $error("reserved misc bits read nonzero");

endmodule : voltage_fault_status_bank

// ### verification/mgmt_host_model.sv
/*
 * Management controller model: issues single-byte register strobes.
 * Assumes the bank takes a strobe at the rising edge it sees it.
 */
module mgmt_host_model (
	input  wire logic                   clk,    // Bank clock
	output fault_status_pkg::reg_req_t  regReq  // Register strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	initial regReq = '0;
	// Software clears by writing ones; one-cycle strobe
	task automatic access(input logic rd, input logic wr, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge clk);
		regReq <= '{rd, wr, a, d};
		@(posedge clk);
		// Released lines show junk, not the last value
		regReq <= '{1'b0, 1'b0, ~a, ~d};
	endtask : access
endmodule : mgmt_host_model

// ### verification/voltage_fault_status_bank_tb_top.sv
/*
 * Self-checking bench for the sticky fault status bank.
 * Assumes the host model for register access and a 200 MHz clock.
 */
`define CHK(act, exp) begin checks++; if ((act) !== (exp)) begin error_cnt++; \
	$display("ERROR t=%0t got %h want %h", $time, act, exp); end end
module voltage_fault_status_bank_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                           clk, rst_b, asfMode, alertEnable, summary, alert;
	logic [7:0]                     rdData;
	logic [23:0]                    s3OptMask, s45OptMask;
	fault_status_pkg::fault_in_t    faultIn, f;
	fault_status_pkg::sleep_state_t sleepState;
	fault_status_pkg::reg_req_t     regReq;
	int                             error_cnt, checks, cycles;
	mgmt_host_model i_host (.clk(clk), .regReq(regReq));
	voltage_fault_status_bank i_dut (.clk(clk), .rst_b(rst_b), .regReq(regReq),
		.regRdData_q(rdData), .faultIn(faultIn), .sleepState(sleepState),
		.s3OptMask(s3OptMask), .s45OptMask(s45OptMask), .asfMode(asfMode),
		.alertEnable(alertEnable), .summaryErrFlag_q(summary), .alert_q(alert));
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		i_host.access(1'b1, 1'b0, a, 8'h00);
		// Data was launched one edge ago and stands until the next read
		@(posedge clk);
		`CHK(rdData, e)
	endtask : rd
	task automatic regs3(input logic [7:0] e1, input logic [7:0] e2, input logic [7:0] e3);
		rd(8'h41, e1);
		rd(8'h42, e2);
		rd(8'h43, e3);
	endtask : regs3
	task automatic pulse(input fault_status_pkg::fault_in_t v);
		@(posedge clk);
		faultIn <= v;
		@(posedge clk);
		faultIn <= '0;
	endtask : pulse
	task automatic clearAll();
		for (int a = 8'h41; a <= 8'h43; a++) i_host.access(1'b0, 1'b1, a[7:0], 8'hFF);
	endtask : clearAll
	task automatic testAwake();
		regs3(8'h00, 8'h00, 8'h00);
		rd(8'h44, 8'h00);
		alertEnable <= 1'b1;
		pulse('1);
		repeat (2) @(posedge clk);
		#1;
		`CHK({summary, alert}, 2'b11)
		regs3(8'hFF, 8'hFF, 8'hFC);
		i_host.access(1'b0, 1'b1, 8'h43, 8'h03);
		rd(8'h43, 8'hFC);
		clearAll();
		regs3(8'h00, 8'h00, 8'h00);
		`CHK({summary, alert}, 2'b00)
		$display("test awake done");
	endtask : testAwake
	task automatic testSleep();
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			sleepState <= i[1] ? fault_status_pkg::SLEEP_S45 : fault_status_pkg::SLEEP_S3;
			// On odd passes only the mask of the current state is set, so a swapped mask shows
			s3OptMask <= {24{i[0] & ~i[1]}};
			s45OptMask <= {24{i[0] & i[1]}};
			pulse('1);
			regs3(8'h00, i[0] ? 8'h80 : 8'hB8, i[0] ? 8'h00 : 8'hC0);
			clearAll();
		end
		sleepState <= fault_status_pkg::SLEEP_S0;
		$display("test sleep done");
	endtask : testSleep
	task automatic testClear();
		f = '0;
		f.voltRange = 16'h8001;
		@(posedge clk);
		faultIn <= f;
		i_host.access(1'b0, 1'b1, 8'h41, 8'h01);
		i_host.access(1'b0, 1'b1, 8'h42, 8'h80);
		rd(8'h41, 8'h01);
		rd(8'h42, 8'h80);
		sleepState <= fault_status_pkg::SLEEP_S3;
		i_host.access(1'b0, 1'b1, 8'h41, 8'h01);
		i_host.access(1'b0, 1'b1, 8'h42, 8'h80);
		rd(8'h41, 8'h00);
		rd(8'h42, 8'h80);
		faultIn <= '0;
		sleepState <= fault_status_pkg::SLEEP_S0;
		clearAll();
		rd(8'h42, 8'h00);
		$display("test clear done");
	endtask : testClear
	task automatic testAsf();
		asfMode <= 1'b1;
		alertEnable <= 1'b0;
		sleepState <= fault_status_pkg::SLEEP_S45;
		f = '0;
		f.voltRange = 16'h8000;
		pulse(f);
		@(posedge clk);
		`CHK({summary, alert}, 2'b10)
		rd(8'h42, 8'h80);
		rd(8'h42, 8'h00);
		sleepState <= fault_status_pkg::SLEEP_S0;
		f.voltRange = 16'h0001;
		pulse(f);
		rd(8'h41, 8'h01);
		rd(8'h41, 8'h00);
		asfMode <= 1'b0;
		sleepState <= fault_status_pkg::SLEEP_S0;
		$display("test asf done");
	endtask : testAsf
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : final_report
	// Whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			error_cnt++;
			final_report();
		end
	end
	initial begin
		{rst_b, asfMode, alertEnable, s3OptMask, s45OptMask, error_cnt, checks, cycles} = '0;
		faultIn = '0;
		sleepState = fault_status_pkg::SLEEP_S0;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		testAwake();
		testSleep();
		testClear();
		testAsf();
		final_report();
	end
endmodule : voltage_fault_status_bank_tb_top
